// file: hw/latc_top.sv
// Trace control: register slave, trigger sequencer, solo state and trace writer.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
module latc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] m_q;
	// Plain two-flop cell; the first stage feeds only the second.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			m_q <= '0;
			q <= '0;
		end else begin
			m_q <= d;
			q <= m_q;
		end
	end
endmodule

module latc_top #(
	parameter int NST = latc_pkg::NST_DEF,
	parameter int MAW = latc_pkg::MAW_DEF,
	parameter int GW = latc_pkg::GW_DEF,
	parameter int SQ = latc_pkg::SQ_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic selftest_reset_n,
	input wire latc_pkg::latc_apb_s apb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [GW-1:0] group_data,
	input wire logic group_sample_en,
	input wire logic [3:0] cmp_hit,
	input wire logic lowpower_req_n,
	input wire logic [1:0] cross_trigger_in,
	input wire logic [5:0] external_trigger_in,
	output logic clock_halt_out,
	output logic mem_we,
	output logic [MAW-1:0] mem_addr,
	output logic [GW+7:0] mem_wdata
);
	import latc_pkg::*;
	localparam int DW = GW + 8;

	////////////////////////////////////////////////////////////////////////////
	// Either reset clears everything; the self-test reset idles high.
	wire rst_n = presetn & selftest_reset_n;
	logic [SYNW-1:0] sync_q;
	latc_sync #(.W(SYNW)) u_sync (
		.clk(pclk),
		.rst_n(rst_n),
		.d({lowpower_req_n, cross_trigger_in, external_trigger_in}),
		.q(sync_q)
	);

	function automatic logic hit_of(input latc_ctl_s c, input logic [3:0] h);
		hit_of = h[c.match_sel] ^ c.match_mode;
	endfunction
	function automatic logic cap_of(input latc_ctl_s c, input logic hit, input logic cm, input logic sen);
		case (c.mode)
			M_EVERY: cap_of = sen;
			M_SIG: cap_of = hit & sen;
			M_CNT: cap_of = cm & sen;
			default: cap_of = hit;
		endcase
	endfunction
	// The clear takes its own cycle, so the period is the limit plus one.
	function automatic logic [CNTW-1:0] cnt_nx(input latc_ctl_s c, input logic [CNTW-1:0] v, input logic hit,
		input logic cm);
		cnt_nx = (cm && c.tally_clear) ? '0 : v + CNTW'(c.tally_source ? hit : 1'b1);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic run_q;
	logic pre_q;
	logic [7:0] solo_q;
	latc_ctl_s ctl_q [NST];
	latc_out_s out_q [NST];
	logic [CNTW-1:0] lim_q [NST];
	latc_ph_e phase_q;
	logic [2:0] cur_q;
	logic [CNTW-1:0] cnt_q;
	logic [CNTW-1:0] scnt_q;
	logic [CNTW-1:0] tcnt_q;
	logic trace_act_q;
	logic [MAW-1:0] wptr_q;
	logic [31:0] rd_d;
	logic wr_v;
	logic [DW-1:0] wr_d;

	wire setup = apb.psel & ~apb.penable;
	wire wr = apb.psel & apb.penable & apb.pwrite;
	wire [2:0] widx = apb.paddr[6:4];
	wire [1:0] wsub = apb.paddr[3:2];
	wire st_reg = (apb.paddr[11:8] == A_ST_PAGE) && !apb.paddr[7] && ({1'b0, widx} < 4'(NST)) && (wsub != SUB_RSV);
	wire top_reg = (apb.paddr == A_CTRL) || (apb.paddr == A_PRE) || (apb.paddr == A_SOLO) ||
		(apb.paddr == A_IDENT) || (apb.paddr == A_STAT) || (apb.paddr == A_WPTR);
	wire map_ok = st_reg || top_reg;
	assign pready = 1'b1;
	assign pslverr = apb.psel & apb.penable & ~map_ok;

	always_comb begin
		rd_d = '0;
		if (st_reg) begin
			case (wsub)
				SUB_CTL: rd_d = 32'(ctl_q[widx]);
				SUB_OUT: rd_d = 32'(out_q[widx]);
				default: rd_d = 32'(lim_q[widx]);
			endcase
		end else begin
			case (apb.paddr)
				A_CTRL: rd_d = 32'(run_q);
				A_PRE: rd_d = 32'(pre_q);
				A_SOLO: rd_d = 32'(solo_q);
				// Address width and state count are readable.
				A_IDENT: rd_d = 32'({4'(NST), 8'(MAW)});
				A_STAT: rd_d = 32'({sync_q, trace_act_q, phase_q, cur_q});
				A_WPTR: rd_d = 32'(wptr_q);
				default: rd_d = '0;
			endcase
		end
	end

	// Read data is caught in the setup cycle so the access cycle needs no wait.
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= '0;
		end else if (setup) begin
			prdata <= rd_d;
		end
	end

	// Writes while running are accepted; software is expected not to do that.
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			pre_q <= 1'b0;
			solo_q <= '0;
		end else if (wr) begin
			if (apb.paddr == A_CTRL) begin
				run_q <= apb.pwdata[0];
			end
			if (apb.paddr == A_PRE) begin
				pre_q <= apb.pwdata[0];
			end
			if (apb.paddr == A_SOLO) begin
				solo_q <= apb.pwdata[7:0];
			end
		end
	end

	for (genvar n = 0; n < NST; n++) begin : g_st
		always_ff @(posedge pclk or negedge rst_n) begin
			if (!rst_n) begin
				ctl_q[n] <= '0;
				out_q[n] <= '0;
				lim_q[n] <= '0;
			end else if (wr && st_reg && widx == 3'(n)) begin
				if (wsub == SUB_CTL) begin
					ctl_q[n] <= latc_ctl_s'(apb.pwdata[CTL_W-1:0]);
				end
				if (wsub == SUB_OUT) begin
					out_q[n] <= latc_out_s'(apb.pwdata[OUT_W-1:0]);
				end
				if (wsub == SUB_LIM) begin
					lim_q[n] <= apb.pwdata[CNTW-1:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	wire latc_ctl_s mc = ctl_q[cur_q];
	wire latc_out_s mo = out_q[cur_q];
	// The solo state is always the top index.
	wire latc_ctl_s sc = ctl_q[NST-1];
	wire running = (phase_q == PH_RUN) && run_q;
	// Solo enable at the top state position.
	wire solo_on = running && solo_q[NST-1];
	wire m_hit = hit_of(mc, cmp_hit);
	wire m_cm = cnt_q == lim_q[cur_q];
	// Only match, tally, timeout, trace and capture mode fields feed the solo state.
	wire s_hit = hit_of(sc, cmp_hit);
	wire s_cm = scnt_q == lim_q[NST-1];
	// Capture only while running with trace active.
	wire m_cap = running && trace_act_q && mc.trace && cap_of(mc, m_hit, m_cm, group_sample_en);
	// Solo capture ends with the run phase.
	wire s_cap = solo_on && sc.trace && cap_of(sc, s_hit, s_cm, group_sample_en);
	wire m_fin = mo.succ >= 4'(NST);
	// Solo timeout ends the whole run.
	wire s_stop = solo_on && s_cm && sc.timeout_final;
	wire latc_hdr_s hm = '{tcnt: tcnt_q[1:0], ovr: 1'b0, st: cur_q,
		typ: (mc.mode == M_CNTDATA) ? TYP_CNT : TYP_DATA};
	// Without queues a collision is marked in the solo word.
	wire latc_hdr_s hs = '{tcnt: tcnt_q[1:0], ovr: (SQ == 0) && m_cap, st: 3'(NST - 1),
		typ: (sc.mode == M_CNTDATA) ? TYP_CNT : TYP_DATA};
	wire [DW-1:0] e_m = {(mc.mode == M_CNTDATA) ? GW'(cnt_q) : group_data, hm};
	wire [DW-1:0] e_s = {(sc.mode == M_CNTDATA) ? GW'(scnt_q) : group_data, hs};

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= PH_IDLE;
			cur_q <= '0;
			cnt_q <= '0;
			scnt_q <= '0;
			trace_act_q <= 1'b0;
			clock_halt_out <= 1'b0;
		end else begin
			case (phase_q)
				PH_IDLE: begin
					clock_halt_out <= 1'b0;
					if (run_q) begin
						phase_q <= PH_RUN;
						cur_q <= '0;
						cnt_q <= '0;
						scnt_q <= '0;
						trace_act_q <= pre_q;
					end
				end
				PH_RUN: begin
					// Clearing run, or reset, stops the sequencer.
					if (!run_q) begin
						phase_q <= PH_IDLE;
					end else if (s_stop) begin
						phase_q <= PH_FINAL;
					end else begin
						// Solo state never moves; only its counter runs.
						if (solo_on) begin
							scnt_q <= cnt_nx(sc, scnt_q, s_hit, s_cm);
						end
						if (m_hit) begin
							trace_act_q <= mo.trace;
							clock_halt_out <= mo.halt;
							if (m_fin) begin
								phase_q <= PH_FINAL;
							end else begin
								cur_q <= mo.succ[2:0];
								cnt_q <= '0;
							end
						end else begin
							cnt_q <= cnt_nx(mc, cnt_q, m_hit, m_cm);
						end
					end
				end
				PH_FINAL: begin
					if (!run_q) begin
						phase_q <= PH_IDLE;
					end
				end
				default: phase_q <= PH_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	if (SQ == 0) begin : g_direct
		assign wr_v = m_cap | s_cap;
		assign wr_d = s_cap ? e_s : e_m;
	end else begin : g_queue
		localparam int PW = $clog2(SQ);
		logic [DW-1:0] qm [2][SQ];
		logic [PW-1:0] wp_q [2];
		logic [PW-1:0] rp_q [2];
		logic [PW:0] qc_q [2];
		logic ovf_q [2];
		logic last_q;
		wire [1:0] push = {s_cap, m_cap};
		wire [DW-1:0] pd [2] = '{e_m, e_s};
		wire [1:0] val = {qc_q[1] != '0, qc_q[0] != '0};
		// Fair drain: alternate when both queues hold data.
		wire gnt1 = val[1] && (!val[0] || !last_q);
		wire [1:0] pop = {gnt1, val[0] && !gnt1};
		assign wr_v = |val;
		assign wr_d = gnt1 ? qm[1][rp_q[1]] : qm[0][rp_q[0]];
		always_ff @(posedge pclk or negedge rst_n) begin
			if (!rst_n) begin
				last_q <= 1'b0;
			end else if (wr_v) begin
				last_q <= gnt1;
			end
		end
		for (genvar g = 0; g < 2; g++) begin : g_q
			wire full = qc_q[g] == (PW + 1)'(SQ);
			always_ff @(posedge pclk) begin
				if (push[g] && !full) begin
					qm[g][wp_q[g]] <= pd[g] | (DW'(ovf_q[g]) << HDR_OVR);
				end
			end
			// Depth must be a power of two for the pointers to wrap.
			always_ff @(posedge pclk or negedge rst_n) begin
				if (!rst_n) begin
					wp_q[g] <= '0;
					rp_q[g] <= '0;
					qc_q[g] <= '0;
					ovf_q[g] <= 1'b0;
				end else begin
					wp_q[g] <= wp_q[g] + PW'(push[g] && !full);
					rp_q[g] <= rp_q[g] + PW'(pop[g]);
					qc_q[g] <= qc_q[g] + (PW + 1)'(push[g] && !full) - (PW + 1)'(pop[g]);
					// Overrun is flagged in the next stored word.
					ovf_q[g] <= (push[g] && full) || (ovf_q[g] && !push[g]);
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			mem_we <= 1'b0;
			mem_addr <= '0;
			mem_wdata <= '0;
			wptr_q <= '0;
			tcnt_q <= '0;
		end else begin
			tcnt_q <= tcnt_q + 1'b1;
			mem_we <= wr_v;
			if (wr_v) begin
				mem_addr <= wptr_q;
				mem_wdata <= wr_d;
				wptr_q <= wptr_q + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!rst_n);
	property p_stop_idle; phase_q == PH_RUN && !run_q |=> phase_q == PH_IDLE; endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("run low did not idle");
	// Queued words may still drain after a stop, so only the direct path is held to this.
	property p_no_cap; (SQ == 0) && !run_q |=> !mem_we; endproperty
	a_no_cap: assert property (p_no_cap) else $error("capture while stopped");
	property p_pre; phase_q == PH_IDLE && run_q |=> trace_act_q == $past(pre_q); endproperty
	a_pre: assert property (p_pre) else $error("prestart trace wrong");
	property p_sync; $past(rst_n) && $past(rst_n, 2) |->
		sync_q == $past({lowpower_req_n, cross_trigger_in, external_trigger_in}, 2); endproperty
	a_sync: assert property (p_sync) else $error("sync latency wrong");
	property p_wptr; wr_v |=> mem_we && mem_addr == $past(wptr_q) && wptr_q == MAW'($past(wptr_q) + 1'b1); endproperty
	a_wptr: assert property (p_wptr) else $error("trace address did not advance");
	property p_tout; s_stop |=> phase_q == PH_FINAL ##1 !s_cap; endproperty
	a_tout: assert property (p_tout) else $error("timeout did not force final");
	property p_fin; (SQ == 0) && phase_q == PH_FINAL |=> !mem_we; endproperty
	a_fin: assert property (p_fin) else $error("trace after final");
	property p_clr; solo_on && s_cm && sc.tally_clear && !s_stop |=> scnt_q == '0; endproperty
	a_clr: assert property (p_clr) else $error("solo counter not cleared");
	property p_trans; running && m_hit && !s_stop |=> trace_act_q == $past(mo.trace); endproperty
	a_trans: assert property (p_trans) else $error("transition trace wrong");
	property p_ovr; SQ == 0 && m_cap && s_cap |=> mem_wdata[HDR_OVR] && mem_wdata[4:2] == 3'(NST - 1); endproperty
	a_ovr: assert property (p_ovr) else $error("collision not marked");
endmodule

// file: inc/latc_pkg.sv
// Constants, types and register map of the trace control block.
// Overview of operation
// - Low-power request, cross and external triggers pass two-flop synchronisers.
// - Functional reset clears all logic; asserts asynchronously, releases synchronously; here rst_n reaches the flops with no release synchroniser.
// - Reset while running stops the analyzer.
// - Trace memory is a circular buffer; address advances per write; depth readable.
// - Trace only while running; prestart trace bit enables trace at run start.
// - Each state transition sets trace on or off from its output entry.
// - Per state, capture control picks one of four capture modes.
// - Highest state is state_total minus one; only it traces independently.
// - Nonzero side queue depth: two queues, fair drain, simultaneous writes absorbed.
// - Zero depth: highest state wins a collision, header bit five marks overwrite.
// - Solo enable bit at highest position makes that state independent.
// - Independent state ignores alternates and loops on itself with counters working.
// - Independent tracing stops at the final state or when run clears.
// - Independent counter match with timeout_final forces the final state.
// - Independent state honours match, timeout, tally and trace fields only; here it also honours its capture mode field.
// - Counter clear costs one clock: limit five counting clocks captures every six.
package latc_pkg;
	localparam int NST_DEF = 5;
	localparam int MAW_DEF = 10;
	localparam int GW_DEF = 64;
	localparam int SQ_DEF = 0;
	localparam int CNTW = 16;
	localparam int SYNW = 9;
	localparam int CTL_W = 9;
	localparam int OUT_W = 6;
	localparam int HDR_OVR = 5;
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_PRE = 12'h004;
	localparam logic [11:0] A_SOLO = 12'h008;
	localparam logic [11:0] A_IDENT = 12'h00C;
	localparam logic [11:0] A_STAT = 12'h010;
	localparam logic [11:0] A_WPTR = 12'h014;
	localparam logic [3:0] A_ST_PAGE = 4'h1;
	localparam logic [1:0] SUB_CTL = 2'h0;
	localparam logic [1:0] SUB_OUT = 2'h1;
	localparam logic [1:0] SUB_LIM = 2'h2;
	localparam logic [1:0] SUB_RSV = 2'h3;
	localparam logic [1:0] TYP_CNT = 2'h0;
	localparam logic [1:0] TYP_DATA = 2'h1;
	typedef enum logic [1:0] {M_EVERY = 2'b00, M_SIG = 2'b01, M_CNT = 2'b10, M_CNTDATA = 2'b11} latc_mode_e;
	typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_RUN = 2'b01, PH_FINAL = 2'b10} latc_ph_e;
	typedef struct packed {
		logic match_mode;
		logic [1:0] match_sel;
		logic tally_clear;
		logic tally_source;
		logic timeout_final;
		logic trace;
		latc_mode_e mode;
	} latc_ctl_s;
	typedef struct packed {
		logic [3:0] succ;
		logic halt;
		logic trace;
	} latc_out_s;
	typedef struct packed {
		logic [1:0] tcnt;
		logic ovr;
		logic [2:0] st;
		logic [1:0] typ;
	} latc_hdr_s;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} latc_apb_s;
endpackage

// file: verification/latc_probe_src.sv
// Model of the on-chip logic that feeds observed groups and comparator hits.
`timescale 1ns/1ns
module latc_probe_src #(
	parameter int GW = 64
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] hit_cmd,
	input wire logic en_cmd,
	output logic [GW-1:0] group_data,
	output logic group_sample_en,
	output logic [3:0] cmp_hit
);
	////////////////////////////////////////////////////////////////////////
	// Flopped on analyzer clock.
	// No authentication or time inputs reach this model.
	// Data keeps changing while the enable is low, as real glitching inputs would.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			group_data <= '0;
			group_sample_en <= 1'b0;
			cmp_hit <= '0;
		end else begin
			group_data <= GW'({$urandom, $urandom});
			group_sample_en <= en_cmd;
			cmp_hit <= hit_cmd;
		end
	end
endmodule

// file: verification/latc_top_tb.sv
// Self-checking bench of the trace control block.
`timescale 1ns/1ns
module latc_top_tb;
	import latc_pkg::*;
	localparam int NST = 5;
	localparam int MAW = 4;
	localparam int GW = 64;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	latc_apb_s apb = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, clock_halt_out, mem_we, err, group_sample_en;
	logic [MAW-1:0] mem_addr, prev_addr;
	logic [GW+7:0] mem_wdata;
	logic [GW-1:0] group_data, prev_gd;
	logic [3:0] cmp_hit;
	logic [3:0] hit_cmd = '0;
	logic en_cmd = 1'b1;
	logic lowpower_req_n = 1'b1;
	logic [1:0] cross_trigger_in = '0;
	logic [5:0] external_trigger_in = '0;
	logic [2:0] exp_st = '0;
	logic [1:0] exp_typ = TYP_DATA;
	logic exp_ovr = 1'b0;
	logic cont = 1'b0;
	int n_fail = 0;
	int num_checks = 0;
	int wr_cnt = 0, gap = 0, cyc = 0, last_cyc = 0, base = 0, cnt = 0, dummy;

	always #25 pclk = ~pclk;

	latc_top #(.NST(NST), .MAW(MAW), .GW(GW), .SQ(0)) i_dut (.pclk(pclk), .presetn(presetn),
		.selftest_reset_n(1'b1), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.group_data(group_data), .group_sample_en(group_sample_en), .cmp_hit(cmp_hit),
		.lowpower_req_n(lowpower_req_n), .cross_trigger_in(cross_trigger_in),
		.external_trigger_in(external_trigger_in), .clock_halt_out(clock_halt_out),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
	latc_probe_src #(.GW(GW)) i_src (.pclk(pclk), .presetn(presetn), .hit_cmd(hit_cmd),
		.en_cmd(en_cmd), .group_data(group_data), .group_sample_en(group_sample_en), .cmp_hit(cmp_hit));

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("Checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	function automatic logic [11:0] sa(input int n, input int s);
		return 12'h100 + 12'(n * 16 + s * 4);
	endfunction

	////////////////////////////////////////////////////////////////////////
	always @(posedge pclk) begin
		cyc++;
		if (mem_we === 1'b1) begin
			if (cont) begin
				chk(64'(mem_addr), 64'(MAW'(prev_addr + 1'b1)));
			end
			chk(64'(mem_wdata[4:0]), 64'({exp_st, exp_typ}));
			chk(64'(mem_wdata[5]), 64'(exp_ovr));
			if (exp_typ == TYP_DATA) begin
				chk(mem_wdata[GW+7:8], prev_gd);
			end
			gap = cyc - last_cyc;
			last_cyc = cyc;
			prev_addr = mem_addr;
			cont = 1'b1;
			wr_cnt++;
		end
		prev_gd = group_data;
	end

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		apb.penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		apb <= '0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
		xfer(1'b0, a, '0);
		chk(64'(rd & mask), 64'(exp));
	endtask

	task automatic start(input logic [31:0] pre);
		wr(A_PRE, pre);
		base = wr_cnt;
		cont = 1'b0;
		wr(A_CTRL, 32'h1);
	endtask

	task automatic stop();
		wr(A_CTRL, 32'h0);
		repeat (3) @(posedge pclk);
		cnt = wr_cnt - base;
	endtask

	task automatic pulse(input int k);
		repeat (k) begin
			@(posedge pclk);
			hit_cmd <= 4'h1;
			@(posedge pclk);
			hit_cmd <= 4'h0;
			repeat (4) @(posedge pclk);
		end
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		results();
	end

	initial begin
		dummy = $urandom(32'h6E3F300D);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk(64'(clock_halt_out), 64'(0));
		rdc(A_IDENT, 32'hFFF, 32'((NST << 8) | MAW));
		xfer(1'b0, 12'h0FC, '0);
		chk(64'({err, rd}), 64'({1'b1, 32'h0}));
		lowpower_req_n <= 1'($urandom);
		cross_trigger_in <= 2'($urandom);
		external_trigger_in <= 6'($urandom);
		repeat (3) @(posedge pclk);
		rdc(A_STAT, 32'h7FC0, {17'h0, lowpower_req_n, cross_trigger_in, external_trigger_in, 6'h0});
		wr(sa(0, 0), 32'h004);
		wr(sa(0, 1), 32'h001);
		start(32'h0);
		repeat (20) @(posedge pclk);
		stop();
		chk(64'(cnt), 64'(0));
		en_cmd <= 1'b0;
		start(32'h1);
		repeat (20) @(posedge pclk);
		stop();
		chk(64'(cnt), 64'(0));
		en_cmd <= 1'b1;
		start(32'h1);
		repeat (20) @(posedge pclk);
		stop();
		chk(64'(cnt >= 18), 64'(1));
		// Modes 1 and 3 after a transition that switches trace on and raises the halt output.
		wr(sa(0, 1), 32'h007);
		wr(sa(1, 1), 32'h005);
		for (int m = 1; m < 4; m += 2) begin
			wr(sa(1, 0), 32'(m) | 32'h4);
			exp_st = 3'd0;
			start(32'h0);
			repeat (10) @(posedge pclk);
			chk(64'(wr_cnt - base), 64'(0));
			exp_st = 3'd1;
			exp_typ = (m == 3) ? TYP_CNT : TYP_DATA;
			pulse(1);
			rdc(A_STAT, 32'h3F, 32'h29);
			chk(64'(clock_halt_out), 64'(1));
			pulse(3);
			chk(64'(clock_halt_out), 64'(0));
			stop();
			chk(64'(cnt), 64'(3));
		end
		exp_typ = TYP_DATA;
		exp_st = 3'(NST - 1);
		exp_ovr = 1'b1;
		wr(sa(0, 1), 32'h001);
		wr(sa(NST - 1, 0), 32'h004);
		wr(A_SOLO, 32'(1 << (NST - 1)));
		start(32'h1);
		repeat (10) @(posedge pclk);
		stop();
		chk(64'(cnt >= 10), 64'(1));
		exp_ovr = 1'b0;
		wr(sa(0, 0), 32'h000);
		wr(sa(NST - 1, 0), 32'h026);
		wr(sa(NST - 1, 2), 32'h5);
		start(32'h0);
		repeat (40) @(posedge pclk);
		@(negedge pclk);
		chk(64'(gap), 64'(6));
		stop();
		wr(sa(NST - 1, 0), 32'h02E);
		start(32'h0);
		repeat (20) @(posedge pclk);
		rdc(A_STAT, 32'h18, 32'h10);
		@(negedge pclk);
		cnt = wr_cnt;
		repeat (20) @(posedge pclk);
		@(negedge pclk);
		chk(64'(wr_cnt - cnt), 64'(0));
		stop();
		start(32'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		rdc(A_CTRL, 32'h1, 32'h0);
		rdc(A_STAT, 32'h18, 32'h0);
		chk(64'(clock_halt_out), 64'(0));
		results();
	end
endmodule
